/* logic/phy_xover_defs.vh */
// Constants for the crossover, address, isolate and LED indication block
// What this block does
// - Reset enables automatic crossover; software changes it via control bits 15:14.
// - Force-crossover bit swaps pairs even with negotiation and auto crossover off.
// - Automatic crossover toggles pair assignment on a pseudo-random schedule from a fixed-seed LFSR.
// - Forced-mode crossover keeps switching at random intervals while no activity.
// - Valid link activity freezes the crossover setting.
// - Forced-mode crossover is off after reset; enabled by PCS config bit 15.
// - Force-crossover bit wins even with forced-mode crossover enabled.
// - Reset captures five address straps into control bits 4:0.
// - Strapped address zero isolates; written address zero does not.
// - Undriven straps resolve to address one.
// - Writing one to basic mode control bit 10 isolates the MII.
// - Isolated: ignore transmit inputs, float MII receive and clock outputs.
// - Isolated: management reads and writes are still served.
// - Isolated: no packet data on media, idles or link pulses continue.
// - Broadcast enable bit accepts writes to address 0x1F.
// - LED mode is control bits 6:5; upper bit only by register write.
// - LED modes map link, activity, collision and duplex onto LEDs.
// - Blink rate for modes 0 and 2 comes from LED control bits 7:6.
// - LED control bit 8 selects receive-only activity.
// - Speed LED high at 100 Mb/s, low at 10, every mode.
// - 10 Mb/s link after seven normal link pulses or one valid packet.
`ifndef PHY_XOVER_DEFS_VH
`define PHY_XOVER_DEFS_VH
`define REG_BASIC_MODE 5'h00
`define REG_PCS_CFG 5'h16
`define REG_LED_CTRL 5'h18
`define REG_PHY_CTRL 5'h19
`define REG_PHY_CTRL2 5'h1C
`define ADDR_BROADCAST 5'h1F
`define ADDR_ZERO 5'h00
`define STRAP_DEFAULT 5'h01
`define BIT_AUTO_XOVER 15
`define BIT_FORCE_XOVER 14
`define BIT_FORCED_AUTO 15
`define BIT_ISOLATE 10
`define BIT_BCAST 11
`define BIT_ACT_RX 8
`define LED_MODE_HI 6
`define LED_MODE_LO 5
`define BLINK_HI 7
`define BLINK_LO 6
`define ADDR_HI 4
`define PHY_CTRL_RESET 16'h8021
`define ZERO16 16'h0000
`define LFSR_SEED 16'hACE1
`define LFSR_TAPS 16'hB400
`define NLP_NEEDED 3'h7
`define STRAP_SETTLE 3'h5
`define XOVER_MIN_MS 16'd1
`define CLK_PER_MS 17'd125000
`define BLINK_BASE 22'h0F4240
`endif

/* logic/sync3.v */
// Three-stage input synchroniser with agreement check
`timescale 1ns/1ps
module sync3 (
	input wire core_clk,
	input wire rst_n,
	input wire d,
	output reg q
);
	reg s1_q;
	reg s2_q;
	reg s3_q;
	// Level accepted once second and third stages agree
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			q <= 1'b0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				q <= s3_q;
		end
	end
endmodule // sync3

/* logic/lfsr16.v */
// Free-running 16-bit Galois LFSR for random crossover timing
`timescale 1ns/1ps
`include "phy_xover_defs.vh"
module lfsr16 (
	input wire core_clk,
	input wire rst_n,
	output reg [15:0] value
);
	// Shift with taps every clock
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			value <= `LFSR_SEED;
		else if (value[0])
			value <= (value >> 1) ^ `LFSR_TAPS;
		else
			value <= value >> 1;
	end
endmodule // lfsr16

/* logic/phy_crossover_address_led_ctrl.v */
// Crossover control, address strap, isolate, broadcast and LED indication
`timescale 1ns/1ps
`include "phy_xover_defs.vh"
module phy_crossover_address_led_ctrl (
	input wire core_clk,
	input wire rst_n,
	input wire mgmt_wr,
	input wire mgmt_rd,
	input wire [4:0] mgmt_phy_addr,
	input wire [4:0] mgmt_reg_addr,
	input wire [15:0] mgmt_wdata,
	output reg [15:0] mgmt_rdata,
	output wire mgmt_hit,
	input wire [4:0] strap_station_address,
	input wire [4:0] strap_driven,
	input wire strap_led_mode_lo,
	input wire an_enabled,
	input wire nlp_pulse,
	input wire flp_seen,
	input wire signal_100_seen,
	input wire valid_10_packet,
	input wire link_lost,
	input wire speed_100,
	input wire full_duplex,
	input wire tx_active,
	input wire rx_active,
	input wire collision,
	input wire [3:0] txd_in,
	input wire tx_en_in,
	output wire [3:0] txd_core,
	output wire tx_en_core,
	output wire mii_out_en,
	output wire media_data_en,
	output reg crossed,
	output reg link_up,
	output reg link_indicator,
	output reg speed_indicator,
	output reg activity_indicator
);
	parameter XOVER_MS = `XOVER_MIN_MS;
	parameter BLINK_BASE = `BLINK_BASE;

	reg [15:0] basic_mode_q;
	reg [15:0] pcs_cfg_q;
	reg [15:0] led_ctrl_q;
	reg [15:0] phy_ctrl_q;
	reg [15:0] phy_ctrl2_q;
	reg strap_iso_q;
	reg strap_done_q;
	reg [2:0] strap_wait_q;
	reg [2:0] nlp_cnt_q;
	reg link10_q;
	reg [16:0] tick_cnt_q;
	reg [15:0] hold_q;
	reg [21:0] blink_cnt_q;
	reg blink_q;
	wire [15:0] rnd;
	wire nlp_s;
	wire [4:0] strap_addr;
	wire [4:0] addr_resolved;
	wire own_addr;
	wire bcast_ok;
	wire wr_hit;
	wire activity;
	wire valid_activity;
	wire auto_on;
	wire forced_auto_on;
	wire isolated;
	wire [1:0] led_mode;
	wire [21:0] blink_limit;
	wire [31:0] blink_shift;

	// Strap and pulse inputs come from pins
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_strap
			sync3 u_s (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.d(strap_station_address[gi]),
				.q(strap_addr[gi])
			);
		end
	endgenerate
	sync3 u_nlp (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.d(nlp_pulse),
		.q(nlp_s)
	);
	lfsr16 u_rnd (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.value(rnd)
	);

	// Undriven straps fall to pull values, giving address one
	assign addr_resolved = (strap_addr & strap_driven) |
		(`STRAP_DEFAULT & ~strap_driven);

	// Address decode: own address, or broadcast for writes only
	assign own_addr = (mgmt_phy_addr == phy_ctrl_q[`ADDR_HI:0]);
	assign bcast_ok = phy_ctrl2_q[`BIT_BCAST] &&
		(mgmt_phy_addr == `ADDR_BROADCAST);
	assign wr_hit = mgmt_wr && (own_addr || bcast_ok);
	assign mgmt_hit = (mgmt_rd && own_addr) || wr_hit;

	// Register file; straps are captured once the synchronisers settle,
	// since their flops start at zero and would read as address zero
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_wait_q <= 3'h0;
			basic_mode_q <= `ZERO16;
			pcs_cfg_q <= `ZERO16;
			led_ctrl_q <= `ZERO16;
			phy_ctrl_q <= `PHY_CTRL_RESET;
			phy_ctrl2_q <= `ZERO16;
			strap_iso_q <= 1'b0;
			strap_done_q <= 1'b0;
		end else begin
			if (!strap_done_q) begin
				if (strap_wait_q != `STRAP_SETTLE) begin
					strap_wait_q <= strap_wait_q + 3'h1;
				end else begin
					strap_done_q <= 1'b1;
					phy_ctrl_q[`ADDR_HI:0] <= addr_resolved;
					phy_ctrl_q[`LED_MODE_LO] <= strap_led_mode_lo;
					phy_ctrl_q[`LED_MODE_HI] <= 1'b0;
					strap_iso_q <= (addr_resolved == `ADDR_ZERO);
				end
			end else if (wr_hit) begin
				case (mgmt_reg_addr)
				`REG_BASIC_MODE: begin
					basic_mode_q <= mgmt_wdata;
					if (!mgmt_wdata[`BIT_ISOLATE])
						strap_iso_q <= 1'b0;
				end
				`REG_PCS_CFG: pcs_cfg_q <= mgmt_wdata;
				`REG_LED_CTRL: led_ctrl_q <= mgmt_wdata;
				`REG_PHY_CTRL: phy_ctrl_q <= mgmt_wdata;
				`REG_PHY_CTRL2: phy_ctrl2_q <= mgmt_wdata;
				default: ;
				endcase
			end
		end
	end

	// Read data, served even while isolated
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			mgmt_rdata <= `ZERO16;
		else if (mgmt_rd && own_addr) begin
			case (mgmt_reg_addr)
			`REG_BASIC_MODE: mgmt_rdata <= basic_mode_q |
				{5'h00, strap_iso_q, 10'h000};
			`REG_PCS_CFG: mgmt_rdata <= pcs_cfg_q;
			`REG_LED_CTRL: mgmt_rdata <= led_ctrl_q;
			`REG_PHY_CTRL: mgmt_rdata <= phy_ctrl_q;
			`REG_PHY_CTRL2: mgmt_rdata <= phy_ctrl2_q;
			default: mgmt_rdata <= `ZERO16;
			endcase
		end
	end

	// Isolation from strap zero or basic mode bit 10
	assign isolated = strap_iso_q || basic_mode_q[`BIT_ISOLATE];
	assign mii_out_en = !isolated;
	assign txd_core = isolated ? 4'h0 : txd_in;
	assign tx_en_core = isolated ? 1'b0 : tx_en_in;
	assign media_data_en = !isolated;

	// 10 Mb/s link: seven normal link pulses or one valid packet
	reg nlp_prev_q;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			nlp_prev_q <= 1'b0;
			nlp_cnt_q <= 3'h0;
			link10_q <= 1'b0;
		end else begin
			nlp_prev_q <= nlp_s;
			if (link_lost) begin
				nlp_cnt_q <= 3'h0;
				link10_q <= 1'b0;
			end else if (valid_10_packet) begin
				link10_q <= 1'b1;
			end else if (nlp_s && !nlp_prev_q) begin
				if (nlp_cnt_q == `NLP_NEEDED - 3'h1)
					link10_q <= 1'b1;
				else
					nlp_cnt_q <= nlp_cnt_q + 3'h1;
			end
		end
	end
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			link_up <= 1'b0;
		else
			link_up <= speed_100 ? (signal_100_seen && !link_lost) : link10_q;
	end

	// Crossover selection
	assign auto_on = phy_ctrl_q[`BIT_AUTO_XOVER] && an_enabled;
	assign forced_auto_on = pcs_cfg_q[`BIT_FORCED_AUTO] && !auto_on;
	assign valid_activity = flp_seen || nlp_s || signal_100_seen;

	// Random hold time between swaps while no activity is seen
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			crossed <= 1'b0;
			tick_cnt_q <= 17'h00000;
			hold_q <= 16'h0000;
		end else if (phy_ctrl_q[`BIT_FORCE_XOVER]) begin
			crossed <= 1'b1;
			hold_q <= 16'h0000;
		end else if (!(auto_on || forced_auto_on)) begin
			crossed <= 1'b0;
		end else if (valid_activity || link_up) begin
			tick_cnt_q <= 17'h00000;
		end else if (tick_cnt_q != `CLK_PER_MS - 17'h1) begin
			tick_cnt_q <= tick_cnt_q + 17'h1;
		end else begin
			tick_cnt_q <= 17'h00000;
			if (hold_q == 16'h0000) begin
				crossed <= rnd[0] ? !crossed : crossed;
				hold_q <= XOVER_MS[15:0] + {12'h000, rnd[4:1]};
			end else
				hold_q <= hold_q - 16'h1;
		end
	end

	// Blink timebase selected by rate field
	assign blink_shift = BLINK_BASE >>
		led_ctrl_q[`BLINK_HI:`BLINK_LO];
	assign blink_limit = blink_shift[21:0];
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			blink_cnt_q <= 22'h000000;
			blink_q <= 1'b0;
		end else if (blink_cnt_q >= blink_limit) begin
			blink_cnt_q <= 22'h000000;
			blink_q <= !blink_q;
		end else
			blink_cnt_q <= blink_cnt_q + 22'h000001;
	end

	// Activity source and LED multiplexing
	assign activity = rx_active ||
		(tx_active && !led_ctrl_q[`BIT_ACT_RX]);
	assign led_mode = phy_ctrl_q[`LED_MODE_HI:`LED_MODE_LO];
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_indicator <= 1'b0;
			speed_indicator <= 1'b0;
			activity_indicator <= 1'b0;
		end else begin
			speed_indicator <= speed_100;
			if (led_mode[0]) begin
				link_indicator <= link_up;
				activity_indicator <= activity;
			end else begin
				link_indicator <= link_up &&
					!(activity && blink_q);
				activity_indicator <= led_mode[1] ? full_duplex :
					(collision && !full_duplex);
			end
		end
	end
endmodule // phy_crossover_address_led_ctrl

/* verif/phy_xover_props.sv */
// Port assertions for the crossover, isolate and LED block
`timescale 1ns/1ps
module phy_xover_props #(
	parameter XOVER_MS = 1,
	parameter BLINK_BASE = 16
) (
	input wire core_clk,
	input wire rst_n,
	input wire mgmt_wr,
	input wire mgmt_rd,
	input wire mgmt_hit,
	input wire [15:0] mgmt_rdata,
	input wire [3:0] txd_in,
	input wire tx_en_in,
	input wire [3:0] txd_core,
	input wire tx_en_core,
	input wire mii_out_en,
	input wire media_data_en,
	input wire speed_100,
	input wire speed_indicator,
	input wire flp_seen,
	input wire signal_100_seen,
	input wire crossed,
	input wire link_up,
	input wire link_indicator
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	chk_hit_needs_req: assert property (mgmt_hit |-> mgmt_wr || mgmt_rd)
		else $error("hit without request");
	chk_rdata_holds: assert property
		(!(mgmt_rd && mgmt_hit) |=> $stable(mgmt_rdata))
		else $error("read data moved");
	chk_isolate_tx_off: assert property
		(!mii_out_en |-> txd_core == 4'h0 && !tx_en_core)
		else $error("transmit passed while isolated");
	chk_tx_pass: assert property
		(mii_out_en |-> txd_core == txd_in && tx_en_core == tx_en_in)
		else $error("transmit not passed");
	chk_media_isolate: assert property (media_data_en == mii_out_en)
		else $error("media data enable wrong");
	chk_speed_follow: assert property
		($past(rst_n) && $stable(speed_100) |-> speed_indicator == speed_100)
		else $error("speed output wrong");
	chk_no_link_dark: assert property (!link_up [*2] |-> !link_indicator)
		else $error("link output lit without link");
	chk_xover_frozen: assert property
		(((flp_seen || signal_100_seen) && !mgmt_wr) [*3] |=> $stable(crossed))
		else $error("crossover moved during activity");
endmodule // phy_xover_props
bind phy_crossover_address_led_ctrl phy_xover_props #(.XOVER_MS(XOVER_MS),
	.BLINK_BASE(BLINK_BASE)) i_props (.core_clk, .rst_n, .mgmt_wr,
	.mgmt_rd, .mgmt_hit, .mgmt_rdata, .txd_in, .tx_en_in, .txd_core,
	.tx_en_core, .mii_out_en, .media_data_en, .speed_100, .speed_indicator,
	.flp_seen, .signal_100_seen, .crossed, .link_up, .link_indicator);

/* verif/mgmt_station_model.sv */
// Station manager model issuing management requests
`timescale 1ns/1ps
module mgmt_station_model (
	input wire core_clk,
	input wire [15:0] mgmt_rdata,
	input wire mgmt_hit,
	output reg mgmt_wr,
	output reg mgmt_rd,
	output reg [4:0] mgmt_phy_addr,
	output reg [4:0] mgmt_reg_addr,
	output reg [15:0] mgmt_wdata
);
	// Idle cycles before each request, raised for a slow station
	int gap = 0;
	initial begin
		mgmt_wr = 1'b0;
		mgmt_rd = 1'b0;
		mgmt_phy_addr = 5'h00;
		mgmt_reg_addr = 5'h00;
		mgmt_wdata = 16'h0000;
	end
	// One request held a cycle; hit sampled settled, data a cycle later
	task xfer(input bit w, input [4:0] pa, input [4:0] ra,
		input [15:0] d, output logic h, output logic [15:0] q);
		repeat (gap) @(posedge core_clk);
		@(posedge core_clk);
		mgmt_wr <= w;
		mgmt_rd <= !w;
		mgmt_phy_addr <= pa;
		mgmt_reg_addr <= ra;
		mgmt_wdata <= d;
		#2 h = mgmt_hit;
		@(posedge core_clk);
		mgmt_wr <= 1'b0;
		mgmt_rd <= 1'b0;
		mgmt_wdata <= ~d;
		@(posedge core_clk);
		#1 q = mgmt_rdata;
	endtask
endmodule // mgmt_station_model

/* verif/phy_crossover_address_led_ctrl_tb.sv */
// Self-checking bench for the crossover, address, isolate and LED block
`timescale 1ns/1ps
module phy_crossover_address_led_ctrl_tb;
	logic core_clk, rst_n, strap_led_mode_lo, an_enabled, nlp_pulse, flp_seen;
	logic signal_100_seen, valid_10_packet, link_lost, speed_100, full_duplex;
	logic tx_active, rx_active, collision, tx_en_in, h;
	logic [4:0] strap_station_address, strap_driven;
	logic [3:0] txd_in;
	logic [15:0] q;
	wire mgmt_wr, mgmt_rd, mgmt_hit, tx_en_core, mii_out_en, media_data_en;
	wire crossed, link_up, link_indicator, speed_indicator, activity_indicator;
	wire [4:0] mgmt_phy_addr, mgmt_reg_addr;
	wire [15:0] mgmt_wdata, mgmt_rdata;
	wire [3:0] txd_core;
	integer fail_count = 0, compares = 0, cycles = 0, n;
	typedef struct {bit w; logic [4:0] ra; logic [15:0] d, e;} row_t;
	row_t rows[5] = '{'{0, 5'h19, 16'h0000, 16'h8023},
		'{0, 5'h16, 16'h0000, 16'h0000}, '{1, 5'h18, 16'h01C0, 16'h01C0},
		'{1, 5'h1C, 16'h0800, 16'h0800}, '{1, 5'h05, 16'hFFFF, 16'h0000}};
	phy_crossover_address_led_ctrl #(.XOVER_MS(1), .BLINK_BASE(16))
		i_phy_crossover_address_led_ctrl (.core_clk, .rst_n, .mgmt_wr,
		.mgmt_rd, .mgmt_phy_addr, .mgmt_reg_addr, .mgmt_wdata, .mgmt_rdata,
		.mgmt_hit, .strap_station_address, .strap_driven, .strap_led_mode_lo,
		.an_enabled, .nlp_pulse, .flp_seen, .signal_100_seen, .valid_10_packet,
		.link_lost, .speed_100, .full_duplex, .tx_active, .rx_active,
		.collision, .txd_in, .tx_en_in, .txd_core, .tx_en_core, .mii_out_en,
		.media_data_en, .crossed, .link_up, .link_indicator, .speed_indicator,
		.activity_indicator);
	mgmt_station_model i_mgmt (.core_clk, .mgmt_rdata, .mgmt_hit, .mgmt_wr,
		.mgmt_rd, .mgmt_phy_addr, .mgmt_reg_addr, .mgmt_wdata);
	// Clock and hang limit
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			fail_count++;
			print_verdict;
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task rd(input [4:0] pa, input [4:0] ra);
		i_mgmt.xfer(1'b0, pa, ra, 16'h0000, h, q);
	endtask
	task wr(input [4:0] pa, input [4:0] ra, input [15:0] d);
		i_mgmt.xfer(1'b1, pa, ra, d, h, q);
	endtask
	task do_reset(input [4:0] a, input [4:0] drv);
		rst_n <= 1'b0;
		strap_station_address <= a;
		strap_driven <= drv;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge core_clk);
	endtask
	task pulses(input int k);
		repeat (k) begin
			@(posedge core_clk) nlp_pulse <= 1'b1;
			repeat (4) @(posedge core_clk);
			nlp_pulse <= 1'b0;
			repeat (4) @(posedge core_clk);
		end
	endtask
	task settle;
		repeat (6) @(posedge core_clk);
	endtask
	task print_verdict;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		{rst_n, nlp_pulse, flp_seen, signal_100_seen, valid_10_packet} = 5'h00;
		{link_lost, speed_100, full_duplex, tx_active, rx_active} = 5'h00;
		{collision, an_enabled, strap_led_mode_lo, tx_en_in} = 4'hF;
		txd_in = 4'hA;
		strap_station_address = 5'h03;
		strap_driven = 5'h1F;
		do_reset(5'h03, 5'h1F);
		collision <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].w) wr(5'h03, rows[i].ra, rows[i].d);
			rd(5'h03, rows[i].ra);
			chk(q, rows[i].e);
		end
		wr(5'h1F, 5'h18, 16'h0100);
		chk({15'h0000, h}, 16'h0001);
		wr(5'h03, 5'h1C, 16'h0000);
		wr(5'h1F, 5'h18, 16'h01C0);
		chk({15'h0000, h}, 16'h0000);
		pulses(6);
		chk({15'h0000, link_up}, 16'h0000);
		pulses(1);
		settle;
		chk({14'h0000, link_up, link_indicator}, 16'h0003);
		tx_active <= 1'b1;
		settle;
		chk({15'h0000, activity_indicator}, 16'h0000);
		wr(5'h03, 5'h18, 16'h0000);
		settle;
		chk({15'h0000, activity_indicator}, 16'h0001);
		wr(5'h03, 5'h19, 16'h8043);
		full_duplex <= 1'b1;
		settle;
		chk({15'h0000, activity_indicator}, 16'h0001);
		wr(5'h03, 5'h19, 16'h8003);
		{full_duplex, collision, speed_100} <= 3'h3;
		settle;
		chk({14'h0000, activity_indicator, speed_indicator}, 16'h0003);
		n = 0;
		repeat (600) @(posedge core_clk) if (link_indicator === 1'b0) n++;
		chk({15'h0000, n != 0}, 16'h0001);
		flp_seen <= 1'b1;
		wr(5'h03, 5'h19, 16'h4023);
		settle;
		chk({15'h0000, crossed}, 16'h0001);
		wr(5'h03, 5'h16, 16'h8000);
		settle;
		chk({15'h0000, crossed}, 16'h0001);
		wr(5'h03, 5'h00, 16'h0400);
		chk({14'h0000, mii_out_en, media_data_en}, 16'h0000);
		rd(5'h03, 5'h19);
		chk(q, 16'h4023);
		wr(5'h03, 5'h00, 16'h0000);
		chk({15'h0000, mii_out_en}, 16'h0001);
		do_reset(5'h00, 5'h1F);
		chk({15'h0000, mii_out_en}, 16'h0000);
		wr(5'h00, 5'h00, 16'h0000);
		chk({15'h0000, mii_out_en}, 16'h0001);
		do_reset(5'h03, 5'h00);
		rd(5'h01, 5'h19);
		chk(q, 16'h8021);
		print_verdict;
	end
endmodule // phy_crossover_address_led_ctrl_tb
